// file: core/gpb_consts.svh
// Register offsets, field positions and reset values of the port bank
`ifndef GPB_CONSTS_SVH
`define GPB_CONSTS_SVH
`define GPB_ADDR_DATA2 16'hFF02
`define GPB_ADDR_DATA3 16'hFF03
`define GPB_ADDR_DATA4 16'hFF04
`define GPB_ADDR_DIR2 16'hFF22
`define GPB_ADDR_DIR3 16'hFF23
`define GPB_ADDR_DIR4 16'hFF24
`define GPB_ADDR_PU2 16'hFF32
`define GPB_ADDR_PU3 16'hFF33
`define GPB_ADDR_PU4 16'hFF34
`define GPB_DIR_RESET 8'hFF
`define GPB_LAT_RESET 8'h00
`define GPB_PU_RESET 8'h00
`define GPB_IMPL2 8'h0F
`define GPB_IMPL3 8'h04
`define GPB_IMPL4 8'hFF
`define GPB_IRQ_A_BIT 1
`define GPB_IRQ_B_BIT 2
`define GPB_RSTPIN_BIT 4
`define GPB_OPT_PORT_BIT 7
`endif

// file: core/gpb_pkg.sv
// Types shared by the port bank modules
package gpb_pkg;
	typedef enum logic [1:0] {
		GPB_SEL_NONE,
		GPB_SEL_DATA,
		GPB_SEL_DIR,
		GPB_SEL_PU
	} gpb_sel_t;
endpackage

// file: core/gpb_port.sv
// One port slice: latch, direction, pull-up enable, pin synchroniser, read mux
`timescale 1ns/1ps
`include "gpb_consts.svh"
module gpb_port #(
	parameter logic [7:0] IMPL = 8'hFF
) (
	input wire logic clk,
	input wire logic arst_n,
	gpb_port_if.port bus
);
	logic [7:0] s1;
	logic [7:0] next_val;
	logic [7:0] cur;

	// Old value of the addressed register, for bit-wise writes
	always_comb begin
		case (bus.sel)
			gpb_pkg::GPB_SEL_DATA: cur = bus.lat;
			gpb_pkg::GPB_SEL_DIR: cur = bus.dir;
			gpb_pkg::GPB_SEL_PU: cur = bus.pu;
			default: cur = 8'h00;
		endcase
		next_val = bus.wdata;
		if (bus.bit_op) begin
			next_val = cur;
			next_val[bus.bit_num] = bus.bit_val;
		end
	end

	// Two-stage pin synchroniser; only the second stage is read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 8'h00;
			bus.pin_sync <= 8'h00;
		end else begin
			s1 <= bus.pin_raw;
			bus.pin_sync <= s1;
		end
	end

	// Direction: unbuilt bits stay one so they read as one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.dir <= `GPB_DIR_RESET;
		end else if (bus.wr && bus.sel == gpb_pkg::GPB_SEL_DIR) begin
			bus.dir <= next_val | ~IMPL;
		end
	end

	// Output latch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.lat <= `GPB_LAT_RESET;
		end else if (bus.wr && bus.sel == gpb_pkg::GPB_SEL_DATA) begin
			bus.lat <= next_val & IMPL;
		end
	end

	// Pull-up enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.pu <= `GPB_PU_RESET;
		end else if (bus.wr && bus.sel == gpb_pkg::GPB_SEL_PU) begin
			bus.pu <= next_val & IMPL;
		end
	end

	// Inputs read the pin, outputs read back the latch
	always_comb begin
		case (bus.rsel)
			gpb_pkg::GPB_SEL_DATA: bus.rdata = ((bus.dir & bus.pin_sync) | (~bus.dir & bus.lat)) & IMPL;
			gpb_pkg::GPB_SEL_DIR: bus.rdata = bus.dir;
			gpb_pkg::GPB_SEL_PU: bus.rdata = bus.pu;
			default: bus.rdata = 8'h00;
		endcase
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_dir_byte_write: assert property (bus.wr && bus.sel == gpb_pkg::GPB_SEL_DIR && !bus.bit_op
		|=> bus.dir == ($past(bus.wdata) | ~IMPL))
		else $error("direction byte write not stored");
	a_dir_bit_alone: assert property (bus.wr && bus.sel == gpb_pkg::GPB_SEL_DIR && bus.bit_op
		|=> ((bus.dir ^ $past(bus.dir)) & ~(8'h01 << $past(bus.bit_num))) == 8'h00)
		else $error("bit write disturbed other direction bits");
	a_unbuilt_dir_ones: assert property ((bus.dir & ~IMPL) == ~IMPL)
		else $error("unbuilt direction bits not one");
endmodule // gpb_port

// file: core/gpb_port_if.sv
// Connection between the bus decoder and one port register slice
`timescale 1ns/1ps
interface gpb_port_if;
	logic wr;
	logic bit_op;
	logic [2:0] bit_num;
	logic bit_val;
	logic [7:0] wdata;
	gpb_pkg::gpb_sel_t sel;
	gpb_pkg::gpb_sel_t rsel;
	logic [7:0] rdata;
	logic [7:0] lat;
	logic [7:0] dir;
	logic [7:0] pu;
	logic [7:0] pin_raw;
	logic [7:0] pin_sync;
	modport ctrl (output wr, bit_op, bit_num, bit_val, wdata, sel, rsel, pin_raw,
		input rdata, lat, dir, pu, pin_sync);
	modport port (input wr, bit_op, bit_num, bit_val, wdata, sel, rsel, pin_raw,
		output rdata, lat, dir, pu, pin_sync);
endinterface

// file: core/gpb_rstpin.sv
// Shared reset/input pin: option byte capture and reset hold
`timescale 1ns/1ps
`include "gpb_consts.svh"
module gpb_rstpin (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pin_raw,
	input wire logic [7:0] opt_byte,
	output logic hold,
	output logic port_mode,
	output logic level
);
	typedef enum logic [1:0] {GPB_RS_WAIT, GPB_RS_LOAD, GPB_RS_RUN} gpb_rs_t;
	gpb_rs_t state;
	logic s1;

	// Pin crosses into the clock domain; starts low so the capture waits for a real sample
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin_raw;
			level <= s1;
		end
	end

	// Option byte is looked at only once reset has let go
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= GPB_RS_WAIT;
			port_mode <= 1'b0;
		end else begin
			case (state)
				GPB_RS_WAIT: state <= GPB_RS_LOAD;
				GPB_RS_LOAD: begin
					// Low pin before the capture keeps us held whatever the byte says
					if (level) begin
						port_mode <= opt_byte[`GPB_OPT_PORT_BIT];
						state <= GPB_RS_RUN;
					end
				end
				default: state <= GPB_RS_RUN;
			endcase
		end
	end

	// Reset request out; in port mode the pin no longer resets
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold <= 1'b1;
		end else begin
			hold <= (state != GPB_RS_RUN) || (!port_mode && !level);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_low_before_read;
		state == GPB_RS_LOAD && !level;
	endsequence
	a_hold_before_read: assert property (s_low_before_read |=> hold && state == GPB_RS_LOAD)
		else $error("released from reset before option byte read");
	a_pin_ignored: assert property (state == GPB_RS_RUN && port_mode |=> !hold)
		else $error("port-mode pin still asserts reset");
endmodule // gpb_rstpin

// file: core/gpb_top.sv
// General-purpose port bank: ports 2, 3 and 4 with shared reset pin
`timescale 1ns/1ps
`include "gpb_consts.svh"
module gpb_top (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [15:0] ADDR,
	input wire logic WR,
	input wire logic BIT_OP,
	input wire logic [2:0] BIT_NUM,
	input wire logic BIT_VAL,
	input wire logic [7:0] WDATA,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [7:0] OPTION_BYTE,
	input wire logic [3:0] PORT2_PIN_IN,
	output logic [3:0] PORT2_PIN_OUT,
	output logic [3:0] PORT2_PIN_OE,
	output logic [3:0] PORT2_PULLUP,
	input wire logic PORT3_PIN_IN,
	output logic PORT3_PIN_OUT,
	output logic PORT3_PIN_OE,
	output logic PORT3_PULLUP,
	input wire logic RESET_SHARED_IN,
	input wire logic [7:0] WIDE_PORT_PINS_IN,
	output logic [7:0] WIDE_PORT_PINS_OUT,
	output logic [7:0] WIDE_PORT_PINS_OE,
	output logic [7:0] WIDE_PORT_PULLUP,
	output logic IRQ_PIN_A_REQ,
	output logic IRQ_PIN_B_REQ,
	output logic SYS_RESET_HOLD
);
	gpb_port_if p2 ();
	gpb_port_if p3 ();
	gpb_port_if p4 ();
	gpb_pkg::gpb_sel_t sel2;
	gpb_pkg::gpb_sel_t sel3;
	gpb_pkg::gpb_sel_t sel4;
	logic hold;
	logic rst_port_mode;
	logic rst_level;
	logic level_a;
	logic level_b;
	logic prev_a;
	logic prev_b;
	logic started;

	// Address decode into a port and a register kind
	always_comb begin
		sel2 = gpb_pkg::GPB_SEL_NONE;
		sel3 = gpb_pkg::GPB_SEL_NONE;
		sel4 = gpb_pkg::GPB_SEL_NONE;
		if (ADDR == `GPB_ADDR_DATA2) begin
			sel2 = gpb_pkg::GPB_SEL_DATA;
		end else if (ADDR == `GPB_ADDR_DIR2) begin
			sel2 = gpb_pkg::GPB_SEL_DIR;
		end else if (ADDR == `GPB_ADDR_PU2) begin
			sel2 = gpb_pkg::GPB_SEL_PU;
		end else if (ADDR == `GPB_ADDR_DATA3) begin
			sel3 = gpb_pkg::GPB_SEL_DATA;
		end else if (ADDR == `GPB_ADDR_DIR3) begin
			sel3 = gpb_pkg::GPB_SEL_DIR;
		end else if (ADDR == `GPB_ADDR_PU3) begin
			sel3 = gpb_pkg::GPB_SEL_PU;
		end else if (ADDR == `GPB_ADDR_DATA4) begin
			sel4 = gpb_pkg::GPB_SEL_DATA;
		end else if (ADDR == `GPB_ADDR_DIR4) begin
			sel4 = gpb_pkg::GPB_SEL_DIR;
		end else if (ADDR == `GPB_ADDR_PU4) begin
			sel4 = gpb_pkg::GPB_SEL_PU;
		end
	end

	// Same write strobe fans out; only the decoded slice acts on it
	assign p2.wr = WR;
	assign p2.bit_op = BIT_OP;
	assign p2.bit_num = BIT_NUM;
	assign p2.bit_val = BIT_VAL;
	assign p2.wdata = WDATA;
	assign p2.sel = sel2;
	assign p2.rsel = sel2;
	assign p2.pin_raw = {4'h0, PORT2_PIN_IN};
	assign p3.wr = WR;
	assign p3.bit_op = BIT_OP;
	assign p3.bit_num = BIT_NUM;
	assign p3.bit_val = BIT_VAL;
	assign p3.wdata = WDATA;
	assign p3.sel = sel3;
	assign p3.rsel = sel3;
	assign p3.pin_raw = {5'h00, PORT3_PIN_IN, 2'h0};
	assign p4.wr = WR;
	assign p4.bit_op = BIT_OP;
	assign p4.bit_num = BIT_NUM;
	assign p4.bit_val = BIT_VAL;
	assign p4.wdata = WDATA;
	assign p4.sel = sel4;
	assign p4.rsel = sel4;
	assign p4.pin_raw = WIDE_PORT_PINS_IN;

	gpb_port #(.IMPL(`GPB_IMPL2)) u_port2 (.clk(CLK), .arst_n(ARST_N), .bus(p2));
	gpb_port #(.IMPL(`GPB_IMPL3)) u_port3 (.clk(CLK), .arst_n(ARST_N), .bus(p3));
	gpb_port #(.IMPL(`GPB_IMPL4)) u_port4 (.clk(CLK), .arst_n(ARST_N), .bus(p4));

	gpb_rstpin u_rstpin (
		.clk(CLK),
		.arst_n(ARST_N),
		.pin_raw(RESET_SHARED_IN),
		.opt_byte(OPTION_BYTE),
		.hold(hold),
		.port_mode(rst_port_mode),
		.level(rst_level)
	);

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			if (sel3 == gpb_pkg::GPB_SEL_DATA) begin
				// Shared pin shows its level only when it is a port input
				RDATA <= p3.rdata | ({7'h00, rst_port_mode & rst_level} << `GPB_RSTPIN_BIT);
			end else begin
				RDATA <= p2.rdata | p3.rdata | p4.rdata;
			end
		end
	end

	// Pin drivers: direction one turns the driver off
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PORT2_PIN_OUT <= 4'h0;
			PORT2_PIN_OE <= 4'h0;
			PORT3_PIN_OUT <= 1'b0;
			PORT3_PIN_OE <= 1'b0;
			WIDE_PORT_PINS_OUT <= 8'h00;
			WIDE_PORT_PINS_OE <= 8'h00;
		end else begin
			PORT2_PIN_OUT <= p2.lat[3:0];
			PORT2_PIN_OE <= ~p2.dir[3:0];
			PORT3_PIN_OUT <= p3.lat[2];
			PORT3_PIN_OE <= ~p3.dir[2];
			WIDE_PORT_PINS_OUT <= p4.lat;
			WIDE_PORT_PINS_OE <= ~p4.dir;
		end
	end

	// Pull-ups only on inputs, so a driven pin never fights its resistor
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PORT2_PULLUP <= 4'h0;
			PORT3_PULLUP <= 1'b0;
			WIDE_PORT_PULLUP <= 8'h00;
		end else begin
			PORT2_PULLUP <= p2.pu[3:0] & p2.dir[3:0];
			PORT3_PULLUP <= p3.pu[2] & p3.dir[2];
			WIDE_PORT_PULLUP <= p4.pu & p4.dir;
		end
	end

	// Interrupt pins see the driven level in output mode, so a latch change fires them
	assign level_a = p2.dir[`GPB_IRQ_A_BIT] ? p2.pin_sync[`GPB_IRQ_A_BIT] : p2.lat[`GPB_IRQ_A_BIT];
	assign level_b = p3.dir[`GPB_IRQ_B_BIT] ? p3.pin_sync[`GPB_IRQ_B_BIT] : p3.lat[`GPB_IRQ_B_BIT];

	// Request pulse on any level change; masking is left to the interrupt controller
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
			IRQ_PIN_A_REQ <= 1'b0;
			IRQ_PIN_B_REQ <= 1'b0;
		end else begin
			prev_a <= level_a;
			prev_b <= level_b;
			IRQ_PIN_A_REQ <= level_a ^ prev_a;
			IRQ_PIN_B_REQ <= level_b ^ prev_b;
		end
	end

	// System reset request from the shared pin
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			SYS_RESET_HOLD <= 1'b1;
		end else begin
			SYS_RESET_HOLD <= hold;
		end
	end

	// Marks the first cycle after reset release, for checking only
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_reset_all_inputs: assert property (!started |-> p4.dir == 8'hFF && p2.dir == 8'hFF && p3.dir == 8'hFF)
		else $error("direction not all ones after reset");
	a_oe_from_dir: assert property (##1 WIDE_PORT_PINS_OE == ~$past(p4.dir)
		&& PORT3_PIN_OE == ~$past(p3.dir[2]))
		else $error("driver enable does not follow direction");
	a_pullup_gating: assert property (##1 WIDE_PORT_PULLUP == ($past(p4.pu) & $past(p4.dir)))
		else $error("pull-up on for a driven pin");
	a_read_mux: assert property (RD && sel4 == gpb_pkg::GPB_SEL_DATA
		|=> RDATA == (($past(p4.dir) & $past(p4.pin_sync)) | (~$past(p4.dir) & $past(p4.lat))))
		else $error("data read mixes pin and latch wrongly");
	a_irq_output_edge: assert property (!p2.dir[1] && $past(!p2.dir[1]) && p2.lat[1] != $past(p2.lat[1])
		|=> IRQ_PIN_A_REQ)
		else $error("driven level change raised no request");
	a_dir2_upper_ones: assert property (RD && sel2 == gpb_pkg::GPB_SEL_DIR |=> RDATA[7:4] == 4'hF)
		else $error("upper direction bits of port 2 not one");
endmodule // gpb_top

// file: verif/gpb_pins.sv
// Board-side model of a group of port pins: drivers, pull-ups and an external source
`timescale 1ns/1ps
module gpb_pins #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] pull_on,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] level
);
	logic [W-1:0] last = '0;
	// Device driver wins, then the board source, then the pull-up
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe[i]) level[i] = out[i];
			else if (ext_en[i]) level[i] = ext_val[i];
			else if (pull_on[i]) level[i] = 1'b1;
			else level[i] = ~last[i]; // Floating line wanders every cycle
		end
	end
	// Remembers the previous level so an undriven line never holds still
	always_ff @(posedge clk) begin
		last <= level;
	end
endmodule // gpb_pins

// file: verif/gpb_top_test.sv
// Self-checking bench for the port bank against a register model
`timescale 1ns/1ps
`include "gpb_consts.svh"
module gpb_top_test;
	logic CLK, ARST_N, WR, BIT_OP, BIT_VAL, RD, RESET_SHARED_IN;
	logic [15:0] ADDR;
	logic [2:0] BIT_NUM;
	logic [7:0] WDATA, RDATA, OPTION_BYTE, WIDE_PORT_PINS_IN, WIDE_PORT_PINS_OUT, WIDE_PORT_PINS_OE, WIDE_PORT_PULLUP;
	logic [3:0] PORT2_PIN_IN, PORT2_PIN_OUT, PORT2_PIN_OE, PORT2_PULLUP;
	logic PORT3_PIN_IN, PORT3_PIN_OUT, PORT3_PIN_OE, PORT3_PULLUP, IRQ_PIN_A_REQ, IRQ_PIN_B_REQ, SYS_RESET_HOLD;
	logic [7:0] dirm [3], latm [3], pum [3], een [3], ev [3];
	logic [7:0] impl [3] = '{`GPB_IMPL2, `GPB_IMPL3, `GPB_IMPL4};
	int fails = 0, checks = 0, cyc = 0, irq_a = 0, irq_b = 0;
	gpb_top DUT (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR(WR), .BIT_OP(BIT_OP), .BIT_NUM(BIT_NUM),
		.BIT_VAL(BIT_VAL), .WDATA(WDATA), .RD(RD), .RDATA(RDATA), .OPTION_BYTE(OPTION_BYTE),
		.PORT2_PIN_IN(PORT2_PIN_IN), .PORT2_PIN_OUT(PORT2_PIN_OUT), .PORT2_PIN_OE(PORT2_PIN_OE),
		.PORT2_PULLUP(PORT2_PULLUP), .PORT3_PIN_IN(PORT3_PIN_IN), .PORT3_PIN_OUT(PORT3_PIN_OUT),
		.PORT3_PIN_OE(PORT3_PIN_OE), .PORT3_PULLUP(PORT3_PULLUP), .RESET_SHARED_IN(RESET_SHARED_IN),
		.WIDE_PORT_PINS_IN(WIDE_PORT_PINS_IN), .WIDE_PORT_PINS_OUT(WIDE_PORT_PINS_OUT),
		.WIDE_PORT_PINS_OE(WIDE_PORT_PINS_OE), .WIDE_PORT_PULLUP(WIDE_PORT_PULLUP),
		.IRQ_PIN_A_REQ(IRQ_PIN_A_REQ), .IRQ_PIN_B_REQ(IRQ_PIN_B_REQ), .SYS_RESET_HOLD(SYS_RESET_HOLD));
	gpb_pins #(.W(4)) pins2 (.clk(CLK), .out(PORT2_PIN_OUT), .oe(PORT2_PIN_OE), .pull_on(PORT2_PULLUP),
		.ext_en(een[0][3:0]), .ext_val(ev[0][3:0]), .level(PORT2_PIN_IN));
	gpb_pins #(.W(1)) pins3 (.clk(CLK), .out(PORT3_PIN_OUT), .oe(PORT3_PIN_OE), .pull_on(PORT3_PULLUP),
		.ext_en(een[1][2]), .ext_val(ev[1][2]), .level(PORT3_PIN_IN));
	gpb_pins #(.W(8)) pins4 (.clk(CLK), .out(WIDE_PORT_PINS_OUT), .oe(WIDE_PORT_PINS_OE), .pull_on(WIDE_PORT_PULLUP),
		.ext_en(een[2]), .ext_val(ev[2]), .level(WIDE_PORT_PINS_IN));
	// Free-running clock, 20 ns period
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// Hang guard and interrupt pulse tallies
	always @(posedge CLK) begin
		cyc++;
		irq_a += (IRQ_PIN_A_REQ === 1'b1);
		irq_b += (IRQ_PIN_B_REQ === 1'b1);
		if (cyc == 30000) begin
			fails++;
			final_report();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Counts: checks %0d, fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Model state after a reset: inputs, latches and pull-ups cleared
	task automatic model_reset();
		for (int p = 0; p < 3; p++) begin
			dirm[p] = 8'hFF;
			latm[p] = 8'h00;
			pum[p] = 8'h00;
		end
	endtask
	// Byte write, model follows; offset 0 data, 1 direction, 2 pull-up
	task automatic wr(input int p, input int kind, input logic [7:0] d);
		@(negedge CLK);
		ADDR = 16'((kind == 0) ? `GPB_ADDR_DATA2 + p : (kind == 1) ? `GPB_ADDR_DIR2 + p : `GPB_ADDR_PU2 + p);
		WDATA = d;
		BIT_OP = 1'b0;
		WR = 1'b1;
		@(negedge CLK);
		WR = 1'b0;
		if (kind == 0) latm[p] = d;
		else if (kind == 1) dirm[p] = d;
		else pum[p] = d;
	endtask
	// Single-bit write to a direction register
	task automatic wr_dir_bit(input int p, input int n, input logic v);
		@(negedge CLK);
		ADDR = 16'(`GPB_ADDR_DIR2 + p);
		BIT_OP = 1'b1;
		BIT_NUM = 3'(n);
		BIT_VAL = v;
		WR = 1'b1;
		@(negedge CLK);
		WR = 1'b0;
		dirm[p][n] = v;
	endtask
	task automatic rd(input int a, output logic [7:0] v);
		@(negedge CLK);
		ADDR = 16'(a);
		RD = 1'b1;
		@(negedge CLK);
		RD = 1'b0;
		v = RDATA;
	endtask
	// Compares registers, data read and pin outputs of one port with the model
	task automatic check_port(input int p);
		logic [7:0] v, kn, ex, oe, d, pu, out;
		d = dirm[p] & impl[p];
		oe = ~dirm[p] & impl[p];
		kn = ~impl[p] | oe | (d & (een[p] | pum[p]));
		ex = (latm[p] & oe) | (d & ((een[p] & ev[p]) | (~een[p] & pum[p])));
		if (p == 1) begin
			kn[4] = 1'b1;
			ex[4] = RESET_SHARED_IN;
		end
		rd(`GPB_ADDR_DIR2 + p, v);
		check(v, dirm[p] | ~impl[p]);
		rd(`GPB_ADDR_PU2 + p, v);
		check(v, pum[p] & impl[p]);
		rd(`GPB_ADDR_DATA2 + p, v);
		check(v & kn, ex & kn);
		oe = (p == 0) ? {4'h0, PORT2_PIN_OE} : (p == 1) ? {5'h00, PORT3_PIN_OE, 2'h0} : WIDE_PORT_PINS_OE;
		pu = (p == 0) ? {4'h0, PORT2_PULLUP} : (p == 1) ? {5'h00, PORT3_PULLUP, 2'h0} : WIDE_PORT_PULLUP;
		out = (p == 0) ? {4'h0, PORT2_PIN_OUT} : (p == 1) ? {5'h00, PORT3_PIN_OUT, 2'h0} : WIDE_PORT_PINS_OUT;
		check(oe, ~dirm[p] & impl[p]);
		check(pu, pum[p] & dirm[p] & impl[p]);
		check(out & oe, latm[p] & ~dirm[p] & impl[p]);
	endtask
	task automatic do_reset(input logic port_mode);
		@(negedge CLK);
		OPTION_BYTE = {port_mode, 7'($urandom)};
		ARST_N = 1'b0;
		repeat (12) @(posedge CLK);
		check(SYS_RESET_HOLD, 8'h01);
		check({4'h0, PORT2_PIN_OE} | WIDE_PORT_PINS_OE | 8'(PORT3_PIN_OE), 8'h00);
		@(negedge CLK);
		ARST_N = 1'b1;
		model_reset();
	endtask
	// Switches an interrupt-sharing pin to output, toggles its latch, counts pulses
	task automatic irq_case(input int p, input int n);
		int base;
		wr(p, 0, 8'h00);
		wr_dir_bit(p, n, 1'b0);
		repeat (8) @(negedge CLK);
		base = (p == 0) ? irq_a : irq_b;
		wr(p, 0, 8'h01 << n);
		repeat (6) @(negedge CLK);
		check(8'((p == 0) ? irq_a - base : irq_b - base), 8'h01);
		wr_dir_bit(p, n, 1'b1);
	endtask
	initial begin
		logic [7:0] v;
		ARST_N = 1'b0;
		{WR, RD, BIT_OP, BIT_VAL, BIT_NUM, ADDR, WDATA} = '0;
		RESET_SHARED_IN = 1'b1;
		OPTION_BYTE = 8'h80;
		for (int p = 0; p < 3; p++) begin
			een[p] = 8'h00;
			ev[p] = 8'h00;
		end
		model_reset();
		void'($urandom(32'h35103066));
		// Reset values with the shared pin as a port input
		do_reset(1'b1);
		repeat (10) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h00);
		for (int p = 0; p < 3; p++) check_port(p);
		$display("Test reset values done");
		// Random register contents and board drive on a randomly chosen port each round
		for (int k = 0; k < 24; k++) begin
			int p;
			p = $urandom % 3;
			wr(p, 1, 8'($urandom));
			wr(p, 0, 8'($urandom));
			wr(p, 2, 8'($urandom));
			een[p] = 8'($urandom) & dirm[p];
			ev[p] = 8'($urandom);
			repeat (5) @(negedge CLK);
			check_port(p);
		end
		$display("Test random ports done");
		// Single-bit direction writes leave the other bits alone
		for (int p = 0; p < 3; p++) begin
			for (int n = 0; n < 8; n++) begin
				wr_dir_bit(p, n, 1'($urandom));
				rd(`GPB_ADDR_DIR2 + p, v);
				check(v, dirm[p] | ~impl[p]);
			end
		end
		rd(16'hFF10, v);
		check(v, 8'h00);
		$display("Test bit writes done");
		for (int p = 0; p < 3; p++) een[p] = 8'h00;
		irq_case(0, `GPB_IRQ_A_BIT);
		irq_case(1, `GPB_IRQ_B_BIT);
		$display("Test interrupt pins done");
		// Port mode: a low shared pin is only data, never a reset
		RESET_SHARED_IN = 1'b0;
		repeat (6) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h00);
		check_port(1);
		RESET_SHARED_IN = 1'b1;
		$display("Test shared pin as input done");
		// Reset mode: a low pin before the option byte is used keeps reset held
		RESET_SHARED_IN = 1'b0;
		do_reset(1'b0);
		repeat (10) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h01);
		RESET_SHARED_IN = 1'b1;
		repeat (10) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h00);
		rd(`GPB_ADDR_DIR4, v);
		check(v, 8'hFF);
		$display("Test shared pin as reset done");
		// Port-mode byte cannot free a pin held low across reset release
		RESET_SHARED_IN = 1'b0;
		do_reset(1'b1);
		repeat (10) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h01);
		RESET_SHARED_IN = 1'b1;
		repeat (10) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h00);
		RESET_SHARED_IN = 1'b0;
		repeat (6) @(negedge CLK);
		check(SYS_RESET_HOLD, 8'h00);
		RESET_SHARED_IN = 1'b1;
		$display("Test held pin in port mode done");
		final_report();
	end
endmodule // gpb_top_test
